/* File: tlih_top.sv */
// Two-level interrupt handler with Avalon-MM register slave
`default_nettype none
module tlih_top
  import tlih_pkg::*;
#(
  parameter int          NSRC    = TLIH_NSRC,
  parameter logic [31:0] AUTOCLR = TLIH_AUTOCLR
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Register bus
  input  wire tlih_avreq_s       avs_req,
  output tlih_avrsp_s            avs_rsp,
  // Sources
  input  wire logic [NSRC-1:0]   src_event,
  // Core sequencer
  input  wire logic              instr_done,
  input  wire logic              return_from_interrupt_done,
  output tlih_call_s             call,
  output logic                   ins_hi,
  output logic                   ins_lo
);
  localparam int SW = $clog2(NSRC);
  localparam int NX = NSRC - TLIH_MAIN_SRC;

  typedef struct packed {
    logic              gie;
    logic [NSRC-1:0]   en;
    logic [NSRC-1:0]   pri;
    logic [NSRC-1:0]   pend;
    logic              ins_hi;
    logic              ins_lo;
    tlih_state_e       st;
    logic              req;
    logic              lvl;
    logic [SW-1:0]     src;
    logic [15:0]       vec;
    logic              wreq;
    logic [31:0]       rdata;
  } tlih_state_s;

  tlih_state_s q;
  tlih_state_s d;

  logic [NSRC-1:0] act;
  logic [NSRC-1:0] hi_one;
  logic [NSRC-1:0] lo_one;
  logic            hi_any;
  logic            lo_any;

  // Eligible requests
  assign act = q.pend & q.en & {NSRC{q.gie}};

  tlih_pick #(.N(NSRC)) u_pick_hi (
    .req    (act & q.pri),
    .onehot (hi_one),
    .any    (hi_any)
  );

  tlih_pick #(.N(NSRC)) u_pick_lo (
    .req    (act & ~q.pri),
    .onehot (lo_one),
    .any    (lo_any)
  );

  logic            win_ok;
  logic            win_lvl;
  logic [SW-1:0]   win_src;
  logic [NSRC-1:0] win_one;
  logic            take;
  logic            wr;
  logic [31:0]     wd;
  logic [NSRC-1:0] pend_w;
  logic [NSRC-1:0] clr;

  always_comb begin
    // High level first, then fixed order; preempt only a low routine
    win_lvl = hi_any;
    win_one = hi_any ? hi_one : lo_one;
    win_ok  = (hi_any && !q.ins_hi) ||
              (lo_any && !q.ins_hi && !q.ins_lo);
    win_src = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (win_one[i]) begin
        win_src = SW'(i);
      end
    end
  end

  assign take = instr_done && q.req && (q.st == TLIH_CALL);
  assign wr   = avs_req.write && !q.wreq;
  assign wd   = avs_req.writedata;

  always_comb begin
    d      = q;
    d.wreq = 1'b1;
    clr    = '0;
    if (take && AUTOCLR[q.src]) begin
      clr[q.src] = 1'b1;
    end
    pend_w = q.pend;
    if (wr) begin
      case (avs_req.address)
        TLIH_ADR_ENA: begin
          d.gie                  = wd[TLIH_GIE_BIT];
          d.en[TLIH_MAIN_SRC-1:0] = wd[TLIH_MAIN_SRC-1:0];
        end
        TLIH_ADR_ENX: begin
          d.en[NSRC-1:TLIH_MAIN_SRC] = wd[NX-1:0];
        end
        TLIH_ADR_PRI: begin
          d.pri[TLIH_MAIN_SRC-1:0] = wd[TLIH_MAIN_SRC-1:0];
        end
        TLIH_ADR_PRX: begin
          d.pri[NSRC-1:TLIH_MAIN_SRC] = wd[NX-1:0];
        end
        TLIH_ADR_PND: begin
          pend_w = wd[NSRC-1:0];
        end
        default: begin
        end
      endcase
    end
    // A hardware event wins over a clear in the same cycle
    d.pend = (pend_w & ~clr) | src_event;

    // Bus answer: one wait cycle, then the access completes
    if ((avs_req.read || avs_req.write) && q.wreq) begin
      d.wreq = 1'b0;
      case (avs_req.address)
        TLIH_ADR_ENA: d.rdata = 32'({q.gie, q.en[TLIH_MAIN_SRC-1:0]});
        TLIH_ADR_ENX: d.rdata = 32'(q.en[NSRC-1:TLIH_MAIN_SRC]);
        TLIH_ADR_PRI: d.rdata = 32'(q.pri[TLIH_MAIN_SRC-1:0]);
        TLIH_ADR_PRX: d.rdata = 32'(q.pri[NSRC-1:TLIH_MAIN_SRC]);
        TLIH_ADR_PND: d.rdata = 32'(q.pend);
        TLIH_ADR_STA: d.rdata = 32'({q.src, 5'h00, q.lvl, q.req, q.ins_hi, q.ins_lo});
        default:      d.rdata = TLIH_RD_NONE;
      endcase
    end

    // Call sequencing, sampled on every clock with ce high
    case (q.st)
      TLIH_IDLE: begin
        if (win_ok) begin
          d.req = 1'b1;
          d.st  = TLIH_CALL;
        end
      end
      TLIH_CALL: begin
        if (take) begin
          d.req = 1'b0;
          d.st  = TLIH_IDLE;
          if (q.lvl) begin
            d.ins_hi = 1'b1;
          end else begin
            d.ins_lo = 1'b1;
          end
        end else if (!win_ok) begin
          d.req = 1'b0;
          d.st  = TLIH_IDLE;
        end
      end
      TLIH_GAP: begin
        // One instruction runs after return before a new call
        d.req = win_ok;
        if (instr_done) begin
          d.st = win_ok ? TLIH_CALL : TLIH_IDLE;
        end
      end
      default: begin
        d.req = 1'b0;
        d.st  = TLIH_IDLE;
      end
    endcase
    if (d.req && !take) begin
      d.lvl = win_lvl;
      d.src = win_src;
      d.vec = TLIH_VEC_BASE + 16'(TLIH_VEC_STEP * 16'(win_src));
    end

    // Return releases the active level, the interrupted routine resumes
    if (return_from_interrupt_done) begin
      d.req = 1'b0;
      d.st  = TLIH_GAP;
      if (q.ins_hi) begin
        d.ins_hi = 1'b0;
      end else begin
        d.ins_lo = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.st     <= TLIH_IDLE;
      q.wreq   <= 1'b1;
      q.vec    <= TLIH_VEC_BASE;
    end else if (ce) begin
      q <= d;
    end
  end

  assign avs_rsp.waitrequest = q.wreq;
  assign avs_rsp.readdata    = q.rdata;
  assign call.req            = q.req;
  assign call.vec            = q.vec;
  assign ins_hi              = q.ins_hi;
  assign ins_lo              = q.ins_lo;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_PEND_SET: assert property (ce && |src_event |=>
    ((q.pend & $past(src_event)) == $past(src_event)))
    else $error("event did not set its pending flag");

  AST_REQ_GATED: assert property (ce ##1 q.req |-> ($past(act) != '0))
    else $error("request raised without an eligible flag");

  AST_HI_SAFE: assert property (take |-> !q.ins_hi)
    else $error("high routine was preempted");

  AST_LO_WAIT: assert property (take && !q.lvl |-> !q.ins_lo)
    else $error("low request entered over an active routine");

  AST_VEC: assert property (q.req |-> (q.vec == TLIH_VEC_BASE +
    16'(TLIH_VEC_STEP * 16'(q.src))) && (q.vec <= TLIH_VEC_LAST))
    else $error("vector address wrong");

  AST_GAP: assert property (ce && return_from_interrupt_done ##1 ce && instr_done |-> !take)
    else $error("call taken before one instruction after return");

  AST_AUTOCLR: assert property (take && ce && AUTOCLR[q.src] && !src_event[q.src]
    && !wr |=> !q.pend[$past(q.src)])
    else $error("auto-clear flag not cleared on vectoring");

  AST_INS_SET: assert property (take && ce && !return_from_interrupt_done |=>
    ($past(q.lvl) ? q.ins_hi : q.ins_lo))
    else $error("in-service bit not set on vectoring");

  AST_RETURN_FROM_INTERRUPT: assert property (ce && return_from_interrupt_done && q.ins_hi |=> !q.ins_hi && q.ins_lo ==
    $past(q.ins_lo))
    else $error("return did not release the high level only");

  AST_BUS: assert property ((avs_req.read || avs_req.write) && q.wreq && ce |=>
    !q.wreq ##1 (q.wreq || !$past(ce)))
    else $error("bus answer timing wrong");

  AST_BUS_IDLE: assert property (ce && !avs_req.read && !avs_req.write |=> q.wreq)
    else $error("bus answered without a request");

  AST_FREEZE: assert property (!ce |=> $stable(q))
    else $error("state changed while clock enable was low");

  AST_PEND_KEEP: assert property (ce && !wr && !take |=>
    ((q.pend & $past(q.pend)) == $past(q.pend)))
    else $error("pending flag lost without a clear");

  AST_PEND_WRITE: assert property (ce && wr && !take &&
    (avs_req.address == TLIH_ADR_PND) |=>
    ((q.pend & NSRC'($past(wd))) == NSRC'($past(wd))))
    else $error("software write did not set its pending flag");

  AST_EN_MAIN: assert property (ce && wr && (avs_req.address == TLIH_ADR_ENA) |=>
    (q.en[TLIH_MAIN_SRC-1:0] == TLIH_MAIN_SRC'($past(wd))))
    else $error("main source enables not written");

  AST_EN_EXT: assert property (ce && wr && (avs_req.address == TLIH_ADR_ENX) |=>
    (q.en[NSRC-1:TLIH_MAIN_SRC] == NX'($past(wd))))
    else $error("extended source enables not written");

  AST_GIE_WRITE: assert property (ce && wr && (avs_req.address == TLIH_ADR_ENA) |=>
    (32'(q.gie) == (($past(wd) >> TLIH_GIE_BIT) & 32'h1)))
    else $error("global enable not written");

  AST_PRI_MAIN: assert property (ce && wr && (avs_req.address == TLIH_ADR_PRI) |=>
    (q.pri[TLIH_MAIN_SRC-1:0] == TLIH_MAIN_SRC'($past(wd))))
    else $error("main priority bits not written");

  AST_GIE_GATE: assert property (ce && !q.gie |=> !q.req)
    else $error("request raised while globally disabled");

  AST_HI_FIRST: assert property (ce && hi_any && !q.ins_hi && !take && !return_from_interrupt_done
    |=> (q.req && q.lvl))
    else $error("high level request not chosen first");

  AST_CALL_HOLD: assert property (ce && q.req && win_ok && !take && !return_from_interrupt_done
    |=> q.req)
    else $error("call request dropped before it was taken");

  AST_TAKE_DROP: assert property (ce && take |=> !q.req)
    else $error("call request still raised after the take");

  AST_RETURN_FROM_INTERRUPT_LO: assert property (ce && return_from_interrupt_done && !q.ins_hi |=> !q.ins_lo)
    else $error("return did not release the low level");

  AST_GAP_REQ: assert property (ce && return_from_interrupt_done ##1 ce && win_ok && !return_from_interrupt_done
    |=> q.req)
    else $error("flag still set after return raised no new request");

  AST_HI_BLOCK: assert property (ce && q.ins_hi |=> !q.req)
    else $error("request raised during a high routine");

  AST_LO_BLOCK: assert property (ce && q.ins_lo && !hi_any |=> !q.req)
    else $error("low request raised during a low routine");

  AST_KEEP_FLAG: assert property (take && ce && !AUTOCLR[q.src] && q.pend[q.src]
    && !wr |=> q.pend[$past(q.src)])
    else $error("flag cleared on vectoring although not auto-clear");

  AST_LATENCY: assert property (ce && (q.st == TLIH_IDLE) && q.gie && !q.ins_hi &&
    !q.ins_lo && ((src_event & q.en) != '0) && !wr && !return_from_interrupt_done ##1
    ce && !take && !return_from_interrupt_done |=> q.req)
    else $error("request not raised two clocks after the flag event");

  COV_TAKE_LO: cover property (take && !q.lvl);
  COV_PREEMPT: cover property (take && q.lvl && q.ins_lo);
  COV_REENTER: cover property (ce && return_from_interrupt_done ##[1:20] take);
  COV_GAP_WAIT: cover property (ce && (q.st == TLIH_GAP) && q.req && instr_done);
  COV_AUTOCLR: cover property (take && AUTOCLR[q.src]);
endmodule : tlih_top
`default_nettype wire

/* File: tlih_pkg.sv */
// Package: constants and carrier types of the two-level interrupt handler
`default_nettype none
package tlih_pkg;
  localparam logic [15:0] TLIH_VEC_BASE = 16'h0003;
  localparam logic [15:0] TLIH_VEC_STEP = 16'h0008;
  localparam logic [15:0] TLIH_VEC_LAST = 16'h0093;
  localparam int          TLIH_NSRC     = 19;
  localparam int          TLIH_MAIN_SRC = 7;
  localparam int          TLIH_GIE_BIT  = 7;
  localparam logic [31:0] TLIH_AUTOCLR  = 32'h0000000f;
  localparam int          TLIH_RESP_CLK = 7;
  localparam logic [4:0]  TLIH_ADR_ENA  = 5'h00;
  localparam logic [4:0]  TLIH_ADR_ENX  = 5'h04;
  localparam logic [4:0]  TLIH_ADR_PRI  = 5'h08;
  localparam logic [4:0]  TLIH_ADR_PRX  = 5'h0c;
  localparam logic [4:0]  TLIH_ADR_PND  = 5'h10;
  localparam logic [4:0]  TLIH_ADR_STA  = 5'h14;
  localparam logic [31:0] TLIH_RD_NONE  = 32'h00000000;

  typedef enum logic [1:0] {
    TLIH_IDLE = 2'b00,
    TLIH_CALL = 2'b01,
    TLIH_GAP  = 2'b10
  } tlih_state_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } tlih_avreq_s;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } tlih_avrsp_s;

  typedef struct packed {
    logic        req;
    logic [15:0] vec;
  } tlih_call_s;
endpackage : tlih_pkg
`default_nettype wire

/* File: tlih_pick.sv */
// Fixed-order picker: lowest index of the request vector wins
`default_nettype none
module tlih_pick #(
  parameter int N = 19
) (
  // Requests
  input  wire logic [N-1:0] req,
  // Winner
  output logic      [N-1:0] onehot,
  output logic              any
);
  logic [N:0] seen;

  assign seen[0] = 1'b0;
  for (genvar i = 0; i < N; i++) begin : g_pick
    assign onehot[i]  = req[i] & ~seen[i];
    assign seen[i+1]  = seen[i] | req[i];
  end
  assign any = seen[N];
endmodule : tlih_pick
`default_nettype wire

/* File: tlih_core.sv */
// Core sequencer model: instruction ends, call takes and returns
`default_nettype none
module tlih_core
  import tlih_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Bench control
  input  wire logic       slow,
  input  wire logic       ret_cmd,
  // Handler link
  input  wire tlih_call_s call,
  output logic            instr_done,
  output logic            return_from_interrupt_done,
  output logic [15:0]     tvec,
  output logic [7:0]      takes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ret_q;
  logic       gap_q;
  logic [1:0] cnt_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {ret_q, gap_q, cnt_q, instr_done, return_from_interrupt_done, tvec, takes} <= '0;
    end else begin
      cnt_q <= (cnt_q == {slow, 1'b0}) ? 2'h0 : cnt_q + 2'h1;
      ret_q <= ret_q | ret_cmd;
      instr_done <= 1'b0;
      return_from_interrupt_done <= 1'b0;
      if (cnt_q == 2'h0) begin
        instr_done <= !ret_q;
        return_from_interrupt_done <= ret_q;
        if (ret_q) ret_q <= ret_cmd;
      end
      // The first instruction end after a return never takes a call
      if (return_from_interrupt_done) gap_q <= 1'b1;
      if (instr_done) gap_q <= 1'b0;
      if (instr_done && call.req && !gap_q) begin
        tvec <= call.vec;
        takes <= takes + 8'h1;
      end
    end
  end
endmodule : tlih_core
`default_nettype wire

/* File: tlih_tb.sv */
// Self-checking bench for the interrupt handler
`default_nettype none
module testbench;
  import tlih_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst, ce, slow, ret_cmd, instr_done, return_from_interrupt_done, ins_hi, ins_lo;
  tlih_avreq_s req;
  tlih_avrsp_s rsp;
  tlih_call_s  call;
  logic [18:0] ev;
  logic [15:0] tvec;
  logic [7:0]  takes;
  logic [31:0] rd;
  int          err_count, checked;
  tlih_top i_tlih_top (.mclk(mclk), .rst(rst), .ce(ce), .avs_req(req), .avs_rsp(rsp),
    .src_event(ev), .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done), .call(call),
    .ins_hi(ins_hi), .ins_lo(ins_lo));
  tlih_core i_tlih_core (.mclk(mclk), .rst(rst), .slow(slow), .ret_cmd(ret_cmd),
    .call(call), .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done), .tvec(tvec),
    .takes(takes));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 60) begin
      err_count++;
      $display("[FAIL] %0t wait ran out", $time);
      give_verdict();
    end
  endtask : hang
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 60);
    rd = rsp.readdata;
    req <= '0;
    hang(n);
  endtask : bus
  task automatic ev_pulse(input logic [18:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= '0;
  endtask : ev_pulse
  task automatic take(input logic [15:0] v);
    logic [7:0] t0;
    int         n;
    t0 = takes;
    n = 0;
    while (takes === t0 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    hang(n);
    chk({16'h0, tvec}, {16'h0, v});
  endtask : take
  task automatic ret();
    int n;
    @(posedge mclk);
    ret_cmd <= 1'b1;
    @(posedge mclk);
    ret_cmd <= 1'b0;
    n = 0;
    while (return_from_interrupt_done !== 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    hang(n);
    @(negedge mclk);
  endtask : ret
  initial begin
    {rst, ce, slow, ret_cmd, ev, req} = '0;
    rst = 1'b1;
    ce = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, TLIH_ADR_PRI, 32'h0); chk(rd, 32'h0);
    bus(1'b0, TLIH_ADR_STA, 32'h0); chk(rd, 32'h0);
    bus(1'b0, 5'h1c, 32'h0); chk(rd, TLIH_RD_NONE);
    bus(1'b1, TLIH_ADR_ENA, 32'h10);
    bus(1'b1, TLIH_ADR_ENX, 32'h6);
    bus(1'b1, TLIH_ADR_PRX, 32'h6);
    ev_pulse(19'h10);
    bus(1'b0, TLIH_ADR_PND, 32'h0); chk(rd, 32'h10);
    chk({31'h0, call.req}, 32'h0);
    bus(1'b1, TLIH_ADR_ENA, 32'h90);
    take(16'h0023);
    chk({30'h0, ins_hi, ins_lo}, 32'h1);
    ev_pulse(19'h200);
    take(16'h004b);
    chk({30'h0, ins_hi, ins_lo}, 32'h3);
    ev_pulse(19'h100);
    repeat (10) @(posedge mclk);
    chk({16'h0, tvec}, 32'h004b);
    bus(1'b0, TLIH_ADR_PND, 32'h0); chk(rd, 32'h310);
    bus(1'b1, TLIH_ADR_PND, 32'h100);
    ret();
    chk({30'h0, ins_hi, ins_lo}, 32'h1);
    take(16'h0043);
    bus(1'b1, TLIH_ADR_PND, 32'h0);
    ret();
    ret();
    chk({30'h0, ins_hi, ins_lo}, 32'h0);
    slow <= 1'b1;
    bus(1'b1, TLIH_ADR_ENA, 32'h0a);
    bus(1'b1, TLIH_ADR_PND, 32'h20a);
    bus(1'b1, TLIH_ADR_ENA, 32'h8a);
    take(16'h004b);
    bus(1'b1, TLIH_ADR_PND, 32'h00a);
    ret();
    take(16'h000b);
    bus(1'b0, TLIH_ADR_PND, 32'h0); chk(rd, 32'h8);
    ret();
    take(16'h001b);
    bus(1'b0, TLIH_ADR_PND, 32'h0); chk(rd, 32'h0);
    ret();
    chk({30'h0, ins_hi, ins_lo}, 32'h0);
    @(posedge mclk);
    ce <= 1'b0;
    ev_pulse(19'h1);
    @(posedge mclk);
    ce <= 1'b1;
    bus(1'b0, TLIH_ADR_PND, 32'h0); chk(rd, 32'h0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
